// [pkg/asrts_pkg.sv]
// Constants, register map and types for the converter start-up and trim controller
package asrts_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 50;
	localparam int RST_MIN_NS = 10000;
	localparam int WAKE_NS = 1000000;
	localparam int ALIGN_MIN_NS = 100;
	localparam int RST_CYCLES = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_CYCLES_DEF = WAKE_NS / CLK_NS;
	localparam int ALIGN_EXTRA = 1;
	localparam int ALIGN_CYCLES = (ALIGN_MIN_NS + CLK_NS - 1) / CLK_NS + ALIGN_EXTRA;
	localparam int CNT_W = 16;

	// ----------------------------------------
	// Device register map
	// ----------------------------------------
	localparam logic [7:0] DEV_TARGET_ADDR = 8'h01;
	localparam logic [7:0] DEV_TRIM_SET_ADDR = 8'h15;
	localparam logic [7:0] DEV_OFF_A_ADDR = 8'h17;
	localparam logic [7:0] DEV_OFF_B_ADDR = 8'h18;
	localparam logic [7:0] DEV_OFF_A_RO_ADDR = 8'h6B;
	localparam logic [7:0] DEV_OFF_B_RO_ADDR = 8'h6C;
	localparam logic [7:0] DEV_HOLD_ADDR = 8'h66;
	localparam logic [15:0] TARGET_ALL = 16'h0004;
	localparam logic [15:0] TARGET_MASTER = 16'h0007;
	localparam logic [15:0] TRIM_SET_RESET = 16'h0000;
	localparam logic [15:0] OFF_TRIM_RESET = 16'h0100;
	localparam logic [15:0] HOLD_RESET_VAL = 16'h8000;
	localparam logic [15:0] HOLD_FIELD_MASK = 16'h003F;
	localparam logic [5:0] HOLD_FORBIDDEN = 6'h01;

	// ----------------------------------------
	// Own APB registers
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CONFIG_OFS = 8'h04;
	localparam logic [7:0] OFFSET_OFS = 8'h08;
	localparam logic [7:0] RAW_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam int CTRL_START = 0;
	localparam int CTRL_ALIGN = 1;
	localparam int CTRL_HOLD = 2;
	localparam int CTRL_TRIM_SET = 3;
	localparam int CTRL_OFF_A = 4;
	localparam int CTRL_OFF_B = 5;
	localparam int CTRL_RAW = 6;
	localparam int CTRL_RAW_ALIGN = 7;
	localparam int CTRL_RAW_LEN = 8;
	localparam int CFG_TRIM_BIT = 8;
	localparam int CFG_FLASH_BIT = 9;
	localparam int CFG_HOLD_START_BIT = 10;
	localparam int OFF_B_LSB = 16;
	localparam int RAW_ADDR_LSB = 16;
	localparam int ST_BUSY = 0;
	localparam int ST_AWAKE = 1;
	localparam int ST_BAD = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_STATE_LSB = 4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} asrts_cmd_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RESET = 3'b001,
		ST_WAKE = 3'b011,
		ST_SEL_REQ = 3'b010,
		ST_SEL_REL = 3'b110,
		ST_DATA_REQ = 3'b111,
		ST_DATA_REL = 3'b101,
		ST_ALIGN = 3'b100
	} asrts_state_type;

endpackage

// [rtl/asrts_host.sv]
// Host controller sequencing reset, wake-up, alignment pulse and trim writes to the converter
// Operation
// - Hold global reset low at least 10 us
// - Wait 1 ms after reset before access
// - Order: reset, wait, program, test, align
// - Flash length change needs fresh alignment
// - Alignment active high, differential, minimum width
// - Synchronous alignment gives deterministic start order
// - Asynchronous alignment lasts minimum plus one cycle
// - Count unit four clocks; never program one
// - Select all channels before writing hold count
// - Host may interpolate trims between diode points
// - Target selector: 0-3 channel, 4 all, 7 master
//
// The implementer's own choice: register access over APB.
module asrts_host
	import asrts_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic global_reset_low,
	output logic align_pulse_pos,
	output logic align_pulse_neg,
	output logic cfg_req,
	output asrts_cmd_type cfg_cmd,
	input wire logic cfg_ack
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	asrts_state_type state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic ack_meta_reg, ack_reg;
	logic awake_reg, bad_reg, refused_reg;
	logic [5:0] hold_reg;
	logic trim_set_reg, flash_reg, hold_start_reg;
	logic [8:0] off_a_reg, off_b_reg;
	logic [7:0] raw_addr_reg;
	logic [15:0] raw_data_reg;
	logic [31:0] prdata_reg;
	logic rst_low_reg, align_reg, req_reg;
	asrts_cmd_type cmd_reg;
	asrts_cmd_type job_reg;
	logic job_align_reg;
	logic wr_en, rd_en, mapped, ctrl_wr, can_cmd, bad_cmd, any_cmd;
	logic [15:0] hold_word;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign pready = 1'b1;
	assign mapped = (paddr == CTRL_OFS) || (paddr == CONFIG_OFS) || (paddr == OFFSET_OFS) ||
		(paddr == RAW_OFS) || (paddr == STATUS_OFS);
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_en = psel && !penable && !pwrite;
	assign ctrl_wr = wr_en && (paddr == CTRL_OFS);
	assign prdata = prdata_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (paddr)
				CONFIG_OFS: prdata_reg <= {21'h0, hold_start_reg, flash_reg, trim_set_reg, 2'h0, hold_reg};
				OFFSET_OFS: prdata_reg <= {7'h0, off_b_reg, 7'h0, off_a_reg};
				RAW_OFS: prdata_reg <= {8'h0, raw_addr_reg, raw_data_reg};
				STATUS_OFS: prdata_reg <= {25'h0, state_reg, refused_reg, bad_reg, awake_reg,
					state_reg != ST_IDLE};
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_reg <= HOLD_RESET_VAL[5:0];
			trim_set_reg <= TRIM_SET_RESET[0];
			flash_reg <= 1'b0;
			hold_start_reg <= 1'b0;
			off_a_reg <= OFF_TRIM_RESET[8:0];
			off_b_reg <= OFF_TRIM_RESET[8:0];
			raw_addr_reg <= 8'h00;
			raw_data_reg <= 16'h0000;
		end else if (wr_en) begin
			if (paddr == CONFIG_OFS) begin
				hold_reg <= pwdata[5:0];
				trim_set_reg <= pwdata[CFG_TRIM_BIT];
				flash_reg <= pwdata[CFG_FLASH_BIT];
				hold_start_reg <= pwdata[CFG_HOLD_START_BIT];
			end
			if (paddr == OFFSET_OFS) begin
				off_a_reg <= pwdata[8:0];
				off_b_reg <= pwdata[OFF_B_LSB +: 9];
			end
			if (paddr == RAW_OFS) begin
				raw_addr_reg <= pwdata[RAW_ADDR_LSB +: 8];
				raw_data_reg <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign any_cmd = |pwdata[CTRL_RAW:CTRL_ALIGN];
	assign can_cmd = (state_reg == ST_IDLE) && awake_reg;
	assign bad_cmd = pwdata[CTRL_HOLD] && (hold_reg == HOLD_FORBIDDEN);
	assign hold_word = (HOLD_RESET_VAL & ~HOLD_FIELD_MASK) | {10'h000, hold_reg};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bad_reg <= 1'b0;
			refused_reg <= 1'b0;
		end else if (ctrl_wr) begin
			bad_reg <= bad_cmd;
			refused_reg <= any_cmd && !pwdata[CTRL_START] && !can_cmd;
		end
	end

	// ----------------------------------------
	// Acknowledge synchroniser
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_meta_reg <= 1'b0;
			ack_reg <= 1'b0;
		end else begin
			ack_meta_reg <= cfg_ack;
			ack_reg <= ack_meta_reg;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			awake_reg <= 1'b0;
			rst_low_reg <= 1'b1;
			align_reg <= 1'b0;
			req_reg <= 1'b0;
			cmd_reg <= '0;
			job_reg <= '0;
			job_align_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					cnt_reg <= '0;
					if (ctrl_wr && pwdata[CTRL_START]) begin
						state_reg <= ST_RESET;
						awake_reg <= 1'b0;
						rst_low_reg <= 1'b0;
					end else if (ctrl_wr && can_cmd && !bad_cmd && any_cmd) begin
						job_align_reg <= pwdata[CTRL_RAW] &&
							(pwdata[CTRL_RAW_ALIGN] || (pwdata[CTRL_RAW_LEN] && flash_reg));
						if (pwdata[CTRL_ALIGN]) begin
							state_reg <= ST_ALIGN;
							align_reg <= 1'b1;
						end else if (pwdata[CTRL_RAW]) begin
							job_reg <= '{addr: raw_addr_reg, data: raw_data_reg};
							state_reg <= ST_DATA_REQ;
							req_reg <= 1'b1;
							cmd_reg <= '{addr: raw_addr_reg, data: raw_data_reg};
						end else begin
							state_reg <= ST_SEL_REQ;
							req_reg <= 1'b1;
							if (pwdata[CTRL_HOLD]) begin
								job_reg <= '{addr: DEV_HOLD_ADDR, data: hold_word};
								cmd_reg <= '{addr: DEV_TARGET_ADDR, data: TARGET_ALL};
							end else if (pwdata[CTRL_TRIM_SET]) begin
								job_reg <= '{addr: DEV_TRIM_SET_ADDR, data: {15'h0000, trim_set_reg}};
								cmd_reg <= '{addr: DEV_TARGET_ADDR, data: TARGET_ALL};
							end else begin
								job_reg <= pwdata[CTRL_OFF_A] ? '{addr: DEV_OFF_A_ADDR, data: {7'h00, off_a_reg}} :
									'{addr: DEV_OFF_B_ADDR, data: {7'h00, off_b_reg}};
								cmd_reg <= '{addr: DEV_TARGET_ADDR, data: TARGET_MASTER};
							end
						end
					end
				end
				ST_RESET: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(RST_CYCLES - 1)) begin
						state_reg <= ST_WAKE;
						rst_low_reg <= 1'b1;
						cnt_reg <= '0;
					end
				end
				ST_WAKE: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(WAKE_CYCLES - 1)) begin
						awake_reg <= 1'b1;
						cnt_reg <= '0;
						if (hold_start_reg && hold_reg != HOLD_FORBIDDEN) begin
							state_reg <= ST_SEL_REQ;
							req_reg <= 1'b1;
							cmd_reg <= '{addr: DEV_TARGET_ADDR, data: TARGET_ALL};
							job_reg <= '{addr: DEV_HOLD_ADDR, data: hold_word};
							job_align_reg <= 1'b1;
						end else begin
							state_reg <= ST_ALIGN;
							align_reg <= 1'b1;
						end
					end
				end
				ST_SEL_REQ: begin
					if (ack_reg) begin
						state_reg <= ST_SEL_REL;
						req_reg <= 1'b0;
					end
				end
				ST_SEL_REL: begin
					if (!ack_reg) begin
						state_reg <= ST_DATA_REQ;
						req_reg <= 1'b1;
						cmd_reg <= job_reg;
					end
				end
				ST_DATA_REQ: begin
					if (ack_reg) begin
						state_reg <= ST_DATA_REL;
						req_reg <= 1'b0;
					end
				end
				ST_DATA_REL: begin
					if (!ack_reg) begin
						cnt_reg <= '0;
						if (job_align_reg) begin
							state_reg <= ST_ALIGN;
							align_reg <= 1'b1;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ALIGN: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(ALIGN_CYCLES - 1)) begin
						state_reg <= ST_IDLE;
						align_reg <= 1'b0;
						cnt_reg <= '0;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	assign global_reset_low = rst_low_reg;
	assign align_pulse_pos = align_reg;
	assign align_pulse_neg = !align_reg;
	assign cfg_req = req_reg;
	assign cfg_cmd = cmd_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [CNT_W-1:0] low_cnt_reg, since_cnt_reg, hi_cnt_reg;
	logic [15:0] last_sel_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_reg <= '0;
			since_cnt_reg <= '0;
			hi_cnt_reg <= '0;
			last_sel_reg <= TARGET_ALL;
		end else begin
			low_cnt_reg <= global_reset_low ? '0 : low_cnt_reg + 1'b1;
			if (!global_reset_low) begin
				since_cnt_reg <= '0;
			end else if (since_cnt_reg != '1) begin
				since_cnt_reg <= since_cnt_reg + 1'b1;
			end
			hi_cnt_reg <= align_pulse_pos ? hi_cnt_reg + 1'b1 : '0;
			if (cfg_req && cfg_cmd.addr == DEV_TARGET_ADDR) begin
				last_sel_reg <= cfg_cmd.data;
			end
		end
	end

	sequence s_data_released;
		state_reg == ST_DATA_REL && !ack_reg;
	endsequence

	sequence s_hold_issue;
		$rose(cfg_req) && cfg_cmd.addr == DEV_HOLD_ADDR;
	endsequence

	chk_reset_width: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(global_reset_low) |-> $past(low_cnt_reg) >= CNT_W'(RST_CYCLES - 1))
		else $error("global reset released too early");

	chk_wake_wait: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(cfg_req) |-> since_cnt_reg >= CNT_W'(WAKE_CYCLES))
		else $error("configuration access before wake-up wait");

	chk_no_early_access: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_req || align_pulse_pos) |-> awake_reg && global_reset_low)
		else $error("access or alignment outside start-up order");

	chk_flash_realign: assert property (@(posedge pclk) disable iff (!presetn)
		s_data_released ##0 job_align_reg |=> align_pulse_pos ##1 align_pulse_pos)
		else $error("no alignment after length write");

	chk_align_pair: assert property (@(posedge pclk) disable iff (!presetn)
		align_pulse_neg != align_pulse_pos)
		else $error("alignment pair not complementary");

	chk_align_width: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(align_pulse_pos) |-> hi_cnt_reg == CNT_W'(ALIGN_CYCLES))
		else $error("alignment pulse width wrong");

	chk_hold_not_one: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_req && cfg_cmd.addr == DEV_HOLD_ADDR) |-> cfg_cmd.data[5:0] != HOLD_FORBIDDEN)
		else $error("hold count of one issued");

	chk_select_first: assert property (@(posedge pclk) disable iff (!presetn)
		s_hold_issue |-> last_sel_reg == TARGET_ALL)
		else $error("hold count written without all-channel target");

	chk_req_stable: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_req && !ack_reg) |=> $stable(cfg_cmd) && cfg_req)
		else $error("command changed before acknowledge");

endmodule

// [dv/asrts_dev_model.sv]
// Behavioural converter model: config registers, write handshake, pin timing monitors
module asrts_dev_model
	import asrts_pkg::*;
(
	input wire logic pclk,
	input wire logic global_reset_low,
	input wire logic align_pulse_pos,
	input wire logic align_pulse_neg,
	input wire logic cfg_req,
	input wire asrts_cmd_type cfg_cmd,
	input wire logic [3:0] ack_dly,
	output logic cfg_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] regs [256];
	logic [15:0] sel_of [256];
	int rst_w = 0, align_w = 0, align_n = 0, since_rel = 0, first_gap = 0, wait_n = 0, pair_bad = 0;
	logic seen_req = 1'b0, grl_q = 1'b1, al_q = 1'b0;
	initial cfg_ack = 1'b0;

	// ----------------------------------------
	// Pins and registers
	// ----------------------------------------
	always @(posedge pclk) begin
		grl_q <= global_reset_low;
		al_q <= align_pulse_pos;
		if (align_pulse_pos) align_w <= al_q ? align_w + 1 : 1;
		if (align_pulse_pos && !al_q) align_n <= align_n + 1;
		if (align_pulse_neg === align_pulse_pos) pair_bad <= pair_bad + 1;
		if (cfg_req && !seen_req) begin
			seen_req <= 1'b1;
			first_gap <= since_rel;
		end
		if (!global_reset_low) begin
			rst_w <= grl_q ? 1 : rst_w + 1;
			since_rel <= 0;
			seen_req <= 1'b0;
			foreach (regs[i]) regs[i] <= 16'h0000;
			regs[8'h17] <= 16'h0100;
			regs[8'h18] <= 16'h0100;
			regs[8'h6B] <= 16'h0100;
			regs[8'h6C] <= 16'h0100;
			regs[8'h66] <= 16'h8000;
		end else begin
			since_rel <= since_rel + 1;
		end
		if (!cfg_req) begin
			cfg_ack <= 1'b0;
			wait_n <= 0;
		end else if (!cfg_ack && global_reset_low) begin
			if (wait_n < ack_dly) begin
				wait_n <= wait_n + 1;
			end else begin
				cfg_ack <= 1'b1;
				sel_of[cfg_cmd.addr] <= regs[8'h01];
				if (cfg_cmd.addr != 8'h6B && cfg_cmd.addr != 8'h6C) regs[cfg_cmd.addr] <= cfg_cmd.data;
				if (cfg_cmd.addr == 8'h17) regs[8'h6B] <= cfg_cmd.data & 16'h01FF;
				if (cfg_cmd.addr == 8'h18) regs[8'h6C] <= cfg_cmd.data & 16'h01FF;
			end
		end
	end
endmodule

// [dv/tb_asrts_host.sv]
// Self-checking bench for the start-up and trim controller
module tb_asrts_host
	import asrts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WAKE = 50;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, grl, alp, aln, cfg_req, cfg_ack;
	logic [3:0] ack_dly = 4'h0;
	asrts_cmd_type cfg_cmd;
	int mismatches = 0, n_compared = 0, n;
	logic [5:0] hv [5];
	logic [15:0] prev;
	logic [8:0] oa, ob;

	initial forever #25 pclk = ~pclk;

	asrts_host #(.WAKE_CYCLES(WAKE)) asrts_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .global_reset_low(grl), .align_pulse_pos(alp),
		.align_pulse_neg(aln), .cfg_req(cfg_req), .cfg_cmd(cfg_cmd), .cfg_ack(cfg_ack));
	asrts_dev_model asrts_dev_model_inst (.pclk(pclk), .global_reset_low(grl), .align_pulse_pos(alp),
		.align_pulse_neg(aln), .cfg_req(cfg_req), .cfg_cmd(cfg_cmd), .ack_dly(ack_dly), .cfg_ack(cfg_ack));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim;
		if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) begin
			chk("pready", 1'b0, 1'b1);
			end_sim();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask

	task automatic cmd(input int b);
		ack_dly <= 4'($urandom_range(5, 0));
		apb(1'b1, CTRL_OFS, 32'h1 << b);
	endtask

	task automatic wait_idle;
		int i;
		i = 0;
		do begin
			apb(1'b0, STATUS_OFS, 32'h0);
			i++;
		end while (rd[ST_BUSY] !== 1'b0 && i < 2000);
		if (i >= 2000) begin
			chk("busy", 1'b1, 1'b0);
			end_sim();
		end
	endtask

	function automatic logic [15:0] exp_hold(input logic [5:0] v, input logic [15:0] p);
		return (v == 6'h01) ? p : (16'h8000 | {10'h000, v});
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (100000) @(posedge pclk);
		chk("run_time", 1'b0, 1'b1);
		end_sim();
	end

	initial begin
		void'($urandom(64543));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFFSET_OFS, 32'h0);
		chk("offset_reset", rd, 32'h01000100);
		apb(1'b0, 8'hFC, 32'h0);
		chk("unmapped_err", err, 1'b1);
		cmd(CTRL_ALIGN);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("early_refused", rd[ST_REFUSED], 1'b1);
		chk("early_align", asrts_dev_model_inst.align_n, 32'h0);
		hv = '{6'h00, 6'h02, 6'h01, 6'h3F, 6'($urandom_range(62, 3))};
		apb(1'b1, CONFIG_OFS, (32'h1 << CFG_HOLD_START_BIT) | 32'(hv[4]));
		cmd(CTRL_START);
		wait_idle();
		chk("awake", rd[ST_AWAKE], 1'b1);
		chk("reset_width", asrts_dev_model_inst.rst_w >= RST_CYCLES, 1'b1);
		chk("wake_gap", asrts_dev_model_inst.first_gap >= WAKE, 1'b1);
		chk("start_hold", asrts_dev_model_inst.regs[8'h66], exp_hold(hv[4], 16'h0));
		chk("start_align", asrts_dev_model_inst.align_n, 32'h1);
		chk("align_width", asrts_dev_model_inst.align_w >= ALIGN_CYCLES, 1'b1);
		foreach (hv[k]) begin
			prev = asrts_dev_model_inst.regs[8'h66];
			apb(1'b1, CONFIG_OFS, 32'(hv[k]));
			cmd(CTRL_HOLD);
			wait_idle();
			chk("hold", asrts_dev_model_inst.regs[8'h66], exp_hold(hv[k], prev));
			chk("hold_bad", rd[ST_BAD], hv[k] == 6'h01);
			chk("hold_sel", asrts_dev_model_inst.sel_of[8'h66], 16'h0004);
		end
		for (int t = 0; t < 2; t++) begin
			apb(1'b1, CONFIG_OFS, 32'(t) << CFG_TRIM_BIT);
			cmd(CTRL_TRIM_SET);
			wait_idle();
			chk("trim_set", asrts_dev_model_inst.regs[8'h15], 16'(t));
			prev = asrts_dev_model_inst.sel_of[8'h15];
			chk("trim_sel", prev == 16'h0004 || prev == 16'h0007, 1'b1);
		end
		oa = 9'($urandom);
		ob = 9'($urandom);
		apb(1'b1, OFFSET_OFS, {7'h00, ob, 7'h00, oa});
		cmd(CTRL_OFF_A);
		wait_idle();
		cmd(CTRL_OFF_B);
		wait_idle();
		chk("off_a", asrts_dev_model_inst.regs[8'h6B], {7'h00, oa});
		chk("off_b", asrts_dev_model_inst.regs[8'h6C], {7'h00, ob});
		chk("off_a_sel", asrts_dev_model_inst.sel_of[8'h17], 16'h0007);
		chk("off_b_sel", asrts_dev_model_inst.sel_of[8'h18], 16'h0007);
		for (int f = 0; f < 3; f++) begin
			n = asrts_dev_model_inst.align_n;
			prev = 16'($urandom);
			apb(1'b1, RAW_OFS, {8'h00, 8'h42, prev});
			apb(1'b1, CONFIG_OFS, 32'(f == 1) << CFG_FLASH_BIT);
			apb(1'b1, CTRL_OFS, (32'h1 << CTRL_RAW) | (32'h1 << ((f == 2) ? CTRL_RAW_ALIGN : CTRL_RAW_LEN)));
			wait_idle();
			chk("raw_align", asrts_dev_model_inst.align_n, 32'(n + (f != 0)));
			chk("raw_data", asrts_dev_model_inst.regs[8'h42], prev);
		end
		n = asrts_dev_model_inst.align_n;
		cmd(CTRL_ALIGN);
		wait_idle();
		chk("align_cmd", asrts_dev_model_inst.align_n, 32'(n + 1));
		chk("align_pair", asrts_dev_model_inst.pair_bad, 32'h0);
		apb(1'b1, CONFIG_OFS, 32'h0);
		cmd(CTRL_START);
		wait_idle();
		chk("dflt_off_a", asrts_dev_model_inst.regs[8'h17], 16'h0100);
		chk("dflt_hold", asrts_dev_model_inst.regs[8'h66], 16'h8000);
		cmd(CTRL_START);
		repeat (5) @(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		chk("mid_reset", {grl, alp, cfg_req}, 3'b100);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("post_release", {grl, alp, cfg_req}, 3'b100);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("post_status", rd[6:0], 7'h00);
		end_sim();
	end
endmodule
